// file: design/lpac_top.sv
// link partner ability capture: read-only partner register over axi4-lite
// assumes negotiation machine delivers received words as one-cycle pulses
// Notes on behaviour
// - bit 15 shows partner next page request
// - bit 14 shows partner acknowledge
// - acknowledge set only by received bursts
// - bit 13 shows partner remote fault
// - bit 12 reserved, reads zero in the base page layout
// - bit 11 shows asymmetric pause support
// - bit 10 shows symmetric pause support
// - bit 9 shows four pair hundred
// - bit 8 shows hundred full duplex
// - bit 7 shows hundred twisted pair
// - bit 6 shows ten full duplex
// - bit 5 shows ten twisted pair
// - low five bits hold selector, reset zero
// - next page layout after next page negotiation
// - selector 00001 means fast ethernet
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module lpac_top
    import lpac_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // negotiation machine side
    input wire lpac_page_t page,
    input wire logic negDone,
    output logic fastEthSelector,
    output logic irq,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [15:0] baseWord; // captured base page
    logic [15:0] nextWord; // captured next page
    logic nextView; // register shows next page layout
    logic [2:0] irqStatus; // sticky events
    logic [2:0] irqMask; // event enables
    logic [2:0] events; // one-cycle event pulses
    logic [7:0] wrAddr; // latched write address
    logic [31:0] wrData; // latched write data
    logic [3:0] wrStrb; // latched strobes
    logic haveAw; // write address held
    logic haveW; // write data held
    logic wrFire; // both halves held, response free
    logic clearStrobe; // write one clear to status
    logic maskStrobe; // mask update
    lpac_rd_t next_rd; // decoded read answer
    logic [15:0] viewWord; // word presented at the partner address

    // write state
    typedef enum logic [2:0] {
        LPAC_W_IDLE = 3'b001,
        LPAC_W_EXEC = 3'b010,
        LPAC_W_RESP = 3'b100
    } lpac_wstate_t;
    lpac_wstate_t wState;

    lpac_page_store u_store (
        .clock(clock),
        .rst(rst),
        .page(page),
        .negDone(negDone),
        .baseWord(baseWord),
        .nextWord(nextWord),
        .nextView(nextView)
    );

    // events: base page, next page, remote fault seen
    assign events = {page.valid && !page.nextPage && page.word[LPAC_BIT_REMOTE_FAULT],
                     page.valid && page.nextPage,
                     page.valid && !page.nextPage};

    assign wrFire = (wState == LPAC_W_EXEC);
    assign clearStrobe = wrFire && wrAddr == LPAC_ADDR_STATUS && wrStrb[0];
    assign maskStrobe = wrFire && wrAddr == LPAC_ADDR_MASK && wrStrb[0];

    lpac_irq #(.WIDTH(3)) u_irq (
        .clock(clock),
        .rst(rst),
        .events(events),
        .clearStrobe(clearStrobe),
        .clearBits(wrData[2:0]),
        .maskStrobe(maskStrobe),
        .maskBits(wrData[2:0]),
        .status(irqStatus),
        .mask(irqMask),
        .irq(irq)
    );

    // selector compare for fast ethernet
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fastEthSelector <= 1'b0;
        end else begin
            fastEthSelector <= baseWord[LPAC_SEL_MSB:0] == LPAC_SEL_FAST_ETH;
        end
    end

    // word at the partner address: base layout passes every bit but the reserved one
    // straight through (np, ack, fault, pause, abilities, selector), next layout later
    assign viewWord = nextView ? nextWord : baseWord;

    // write channel capture, address and data in either order
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            haveAw <= 1'b0;
            wrAddr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            haveAw <= 1'b1;
            wrAddr <= s_axi_awaddr;
        end else if (wrFire) begin
            haveAw <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            haveW <= 1'b0;
            wrData <= 32'h00000000;
            wrStrb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            haveW <= 1'b1;
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
        end else if (wrFire) begin
            haveW <= 1'b0;
        end
    end

    // readies are registered: offered in LPAC_W_IDLE while the half is not held
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= wState == LPAC_W_IDLE && !haveAw && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= wState == LPAC_W_IDLE && !haveW && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // write sequencing: exec one cycle, then response
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wState <= LPAC_W_IDLE;
        end else begin
            unique case (wState)
                LPAC_W_IDLE: begin
                    if (haveAw && haveW) begin
                        wState <= LPAC_W_EXEC;
                    end
                end
                LPAC_W_EXEC: begin
                    wState <= LPAC_W_RESP;
                end
                LPAC_W_RESP: begin
                    if (s_axi_bvalid && s_axi_bready) begin
                        wState <= LPAC_W_IDLE;
                    end
                end
            endcase
        end
    end

    // write response; partner register writes are ignored but answered okay
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LPAC_RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            // the partner word is never written, so ack stays hardware owned
            if (wrAddr == LPAC_ADDR_ABILITY || wrAddr == LPAC_ADDR_STATUS ||
                wrAddr == LPAC_ADDR_MASK || wrAddr == LPAC_ADDR_VIEW) begin
                s_axi_bresp <= LPAC_RESP_OKAY;
            end else begin
                s_axi_bresp <= LPAC_RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read decode
    always_comb begin
        next_rd.data = 32'h00000000;
        next_rd.resp = LPAC_RESP_OKAY;
        unique case (s_axi_araddr)
            LPAC_ADDR_ABILITY: next_rd.data = {16'h0000, viewWord};
            LPAC_ADDR_STATUS: next_rd.data = {29'h0, irqStatus};
            LPAC_ADDR_MASK: next_rd.data = {29'h0, irqMask};
            LPAC_ADDR_VIEW: next_rd.data = {31'h0, nextView};
            default: next_rd.resp = LPAC_RESP_SLVERR; // unmapped
        endcase
    end

    // read channel: one read at a time, answer the cycle after accept
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= LPAC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rd.data;
            s_axi_rresp <= next_rd.resp;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule // lpac_top

// file: design/lpac_pkg.sv
// package for the link partner ability capture block
// assumes a 32-bit axi4-lite register bus and one 100 MHz clock
package lpac_pkg;
    // register byte addresses (printed offset 0x5 is an index, so byte address is 4x)
    localparam logic [3:0] LPAC_IDX_ABILITY = 4'h5;
    localparam logic [7:0] LPAC_ADDR_ABILITY = 8'h14;
    localparam logic [7:0] LPAC_ADDR_STATUS = 8'h40;
    localparam logic [7:0] LPAC_ADDR_MASK = 8'h44;
    localparam logic [7:0] LPAC_ADDR_VIEW = 8'h48;
    // base page field positions
    localparam int LPAC_BIT_NEXT_PAGE = 15;
    localparam int LPAC_BIT_ACK = 14;
    localparam int LPAC_BIT_REMOTE_FAULT = 13;
    localparam int LPAC_BIT_RESERVED = 12;
    localparam int LPAC_BIT_ASYM = 11;
    localparam int LPAC_BIT_PAUSE = 10;
    localparam int LPAC_BIT_T4 = 9;
    localparam int LPAC_BIT_HUNDRED_FD = 8;
    localparam int LPAC_BIT_HUNDRED = 7;
    localparam int LPAC_BIT_TEN_FD = 6;
    localparam int LPAC_BIT_TEN = 5;
    localparam int LPAC_SEL_MSB = 4;
    // selector code for the fast ethernet protocol
    localparam logic [4:0] LPAC_SEL_FAST_ETH = 5'h01;
    localparam logic [15:0] LPAC_WORD_RESET = 16'h0000;
    // interrupt status bits
    localparam int LPAC_IRQ_BASE = 0;
    localparam int LPAC_IRQ_NEXT = 1;
    localparam int LPAC_IRQ_FAULT = 2;
    localparam logic [2:0] LPAC_IRQ_RESET = 3'h0;
    // axi responses
    localparam logic [1:0] LPAC_RESP_OKAY = 2'h0;
    localparam logic [1:0] LPAC_RESP_SLVERR = 2'h2;

    // one received link code word from the negotiation machine
    typedef struct packed {
        logic valid;      // one-cycle pulse
        logic nextPage;   // word is a next page, not the base page
        logic [15:0] word;
    } lpac_page_t;

    // read answer carrier
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } lpac_rd_t;
endpackage

// file: design/lpac_page_store.sv
// holds the base page and next page words captured from partner bursts
// assumes page pulses come only from the negotiation machine
`timescale 1ns/1ps
module lpac_page_store
    import lpac_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire lpac_page_t page,
    input wire logic negDone,
    output logic [15:0] baseWord,
    output logic [15:0] nextWord,
    output logic nextView
);
    // base word capture; reserved bit forced to zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            baseWord <= LPAC_WORD_RESET;
        end else if (page.valid && !page.nextPage) begin
            baseWord <= page.word & ~(16'h0001 << LPAC_BIT_RESERVED);
        end
    end

    // next page capture
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nextWord <= LPAC_WORD_RESET;
        end else if (page.valid && page.nextPage) begin
            nextWord <= page.word;
        end
    end

    // view flips to next page once negotiation ends with next pages used
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nextView <= 1'b0;
        end else if (page.valid && !page.nextPage) begin
            nextView <= 1'b0; // new base page restarts the exchange
        end else if (negDone && baseWord[LPAC_BIT_NEXT_PAGE]) begin
            nextView <= 1'b1;
        end
    end
endmodule // lpac_page_store

// file: design/lpac_irq.sv
// sticky event flags, write one to clear, masked onto one level output
// assumes events are one-cycle pulses
`timescale 1ns/1ps
module lpac_irq
    import lpac_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] events,
    input wire logic clearStrobe,
    input wire logic [WIDTH-1:0] clearBits,
    input wire logic maskStrobe,
    input wire logic [WIDTH-1:0] maskBits,
    output logic [WIDTH-1:0] status,
    output logic [WIDTH-1:0] mask,
    output logic irq
);
    // set beats clear in the same cycle so no event is lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= (status & ~(clearStrobe ? clearBits : '0)) | events;
        end
    end

    // mask register, one enables the bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask <= '0;
        end else if (maskStrobe) begin
            mask <= maskBits;
        end
    end

    // registered level output
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status & ~(clearStrobe ? clearBits : '0)) | events) & (maskStrobe ? maskBits : mask));
        end
    end
endmodule // lpac_irq

// file: testbench/lpac_properties.sv
// port-level properties of the partner ability capture block
// assumes it is bound onto lpac_top and sees only its ports
`timescale 1ns/1ps
module lpac_properties
    import lpac_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire lpac_page_t page,
    input wire logic fastEthSelector,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // base page word arriving from the partner
    sequence s_base_rx; page.valid && !page.nextPage; endsequence
    // read address accepted
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    // both write halves accepted in one cycle
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence

    a_sel_decode: assert property (
        s_base_rx |-> ##2
            fastEthSelector == ($past(page.word[LPAC_SEL_MSB:0], 2) == LPAC_SEL_FAST_ETH))
        else $error("selector flag wrong");
    a_sel_quiet: assert property (
        !page.valid ##1 !page.valid |=> $stable(fastEthSelector))
        else $error("flag moved without a page");
    a_rd_answer: assert property (
        s_rd_take |=> s_axi_rvalid) else $error("read answer late");
    a_rd_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_wr_answer: assert property (
        s_wr_take |-> ##3 s_axi_bvalid) else $error("write answer late");
    a_wr_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
    a_reserved_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[LPAC_BIT_RESERVED])
        else $error("reserved bits set");
    a_ability_okay: assert property (
        s_rd_take and s_axi_araddr == LPAC_ADDR_ABILITY |=> s_axi_rresp == LPAC_RESP_OKAY)
        else $error("ability read refused");
endmodule // lpac_properties

// file: testbench/lpac_partner_model.sv
// remote link partner as delivered by the negotiation machine
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
module lpac_partner_model
    import lpac_pkg::*;
(
    input wire logic clock,
    output lpac_page_t page,
    output logic negDone
);
    initial begin
        page = '0;
        negDone = 1'b0;
    end
    // one received word, valid one cycle; word lines then show garbage
    task automatic send_page(input logic np, input logic [15:0] w);
        page <= '{valid: 1'b1, nextPage: np, word: w};
        @(posedge clock);
        page <= '{valid: 1'b0, nextPage: !np, word: ~w};
        // one idle edge so a following call never drives page twice in a step
        @(posedge clock);
    endtask
    // negotiation complete, one cycle
    task automatic finish_neg();
        negDone <= 1'b1;
        @(posedge clock);
        negDone <= 1'b0;
    endtask
endmodule // lpac_partner_model

// file: testbench/link_partner_ability_capture_tb.sv
// bench: axi4-lite reads and writes against captured partner pages
// assumes lpac_top, lpac_partner_model and lpac_properties are compiled
`timescale 1ns/1ps
module link_partner_ability_capture_tb
    import lpac_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    lpac_page_t page;
    logic negDone, fastEthSelector, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int mismatches = 0;
    int cmp_count = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    lpac_partner_model i_lpac_partner_model(.clock, .page, .negDone);
    lpac_top i_lpac_top(.clock, .rst, .page, .negDone, .fastEthSelector, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask
    // both halves offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic da, dw;
        da = 0;
        dw = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1;
        while (!(da && dw)) begin
            @(posedge clock);
            if (!da && s_axi_awready) begin
                da = 1;
                s_axi_awvalid <= 0;
            end
            if (!dw && s_axi_wready) begin
                dw = 1;
                s_axi_wvalid <= 0;
            end
        end
        s_axi_bready <= 1;
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task rd(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        chk_word(n, e, s_axi_rdata);
        chk_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    task wrap_up;
        $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        rd("ability", LPAC_ADDR_ABILITY, 32'h0, LPAC_RESP_OKAY);
        rd("status", LPAC_ADDR_STATUS, 32'h0, LPAC_RESP_OKAY);
        rd("mask", LPAC_ADDR_MASK, 32'h0, LPAC_RESP_OKAY);
        $display("test reset done");
        // walking one, reserved bit always offered set to prove it is dropped
        for (int i = 0; i < 16; i++) begin
            i_lpac_partner_model.send_page(1'b0, 16'h1000 | (16'h0001 << i));
            rd("ability", LPAC_ADDR_ABILITY, {16'h0, (16'h0001 << i) & 16'hefff},
               LPAC_RESP_OKAY);
            chk_bit("fastEth", i == 0, fastEthSelector);
        end
        $display("test fields done");
        // software write leaves acknowledge bit untouched on purpose
        wr(LPAC_ADDR_ABILITY, 32'h0000bfff, LPAC_RESP_OKAY);
        rd("ability", LPAC_ADDR_ABILITY, 32'h8000, LPAC_RESP_OKAY);
        wr(8'h80, 32'h1, LPAC_RESP_SLVERR);
        rd("unmapped", 8'h80, 32'h0, LPAC_RESP_SLVERR);
        $display("test writes done");
        // base events and the remote fault event, masked so far
        chk_bit("irq", 1'b0, irq);
        rd("status", LPAC_ADDR_STATUS, 32'h5, LPAC_RESP_OKAY);
        wr(LPAC_ADDR_MASK, 32'h7, LPAC_RESP_OKAY);
        rd("mask", LPAC_ADDR_MASK, 32'h7, LPAC_RESP_OKAY);
        chk_bit("irq", 1'b1, irq);
        wr(LPAC_ADDR_STATUS, 32'h5, LPAC_RESP_OKAY);
        rd("status", LPAC_ADDR_STATUS, 32'h0, LPAC_RESP_OKAY);
        chk_bit("irq", 1'b0, irq);
        $display("test irq done");
        // next page exchange switches the view, a new base page restores it
        i_lpac_partner_model.send_page(1'b0, 16'h8001);
        i_lpac_partner_model.send_page(1'b1, 16'h4123);
        i_lpac_partner_model.finish_neg();
        rd("view", LPAC_ADDR_VIEW, 32'h1, LPAC_RESP_OKAY);
        rd("ability", LPAC_ADDR_ABILITY, 32'h4123, LPAC_RESP_OKAY);
        rd("status", LPAC_ADDR_STATUS, 32'h3, LPAC_RESP_OKAY);
        chk_bit("irq", 1'b1, irq);
        i_lpac_partner_model.send_page(1'b0, 16'h0021);
        rd("view", LPAC_ADDR_VIEW, 32'h0, LPAC_RESP_OKAY);
        rd("ability", LPAC_ADDR_ABILITY, 32'h0021, LPAC_RESP_OKAY);
        $display("test next page done");
        wrap_up;
    end

    // cut a hang short, far beyond the expected run
    initial begin
        #100000;
        mismatches++;
        wrap_up;
    end
endmodule // link_partner_ability_capture_tb

bind lpac_top lpac_properties i_lpac_properties(.clock, .rst, .page, .fastEthSelector,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
